// ### rtl/mct_pkg.sv
// package for the data-move / call timing decoder
// assumes a single 10 MHz core clock and synchronous active-low reset
package mct_pkg;

  // operand forms of the data transfer group
  typedef enum logic [3:0] {
    MCT_F_REG,
    MCT_F_IMM,
    MCT_F_IMM_ZX,
    MCT_F_IMM_OX,
    MCT_F_LD_SHORT,
    MCT_F_LD_LONG,
    MCT_F_ST_SHORT,
    MCT_F_ST_LONG,
    MCT_F_LD_IND_W,
    MCT_F_LD_IND_D,
    MCT_F_ST_IND_W,
    MCT_F_ST_IND_D,
    MCT_F_LD_DISP_W,
    MCT_F_LD_DISP_D
  } mct_form_e;

  // register operand size: byte_reg_operand, word_reg_operand, dword_reg_operand
  typedef enum logic [1:0] {
    MCT_SZ_BYTE,
    MCT_SZ_WORD,
    MCT_SZ_DWORD
  } mct_size_e;

  // program flow operations
  typedef enum logic [1:0] {
    MCT_K_ABSOLUTE_PAGE_JSR,
    MCT_K_LONG_JSR_OP,
    MCT_K_SUBROUTINE_EXIT,
    MCT_K_INTERRUPT_EXIT
  } mct_flow_e;

  typedef logic [2:0]  mct_len_t;
  typedef logic [5:0]  mct_states_t;
  typedef logic [23:0] mct_pc_t;

  // binary mode encoding lengths
  localparam mct_len_t    MCT_LEN_REG      = 3'h3;
  localparam mct_len_t    MCT_LEN_IMM8     = 3'h4;
  localparam mct_len_t    MCT_LEN_IMM16    = 3'h5;
  localparam mct_len_t    MCT_LEN_SHORT    = 3'h4;
  localparam mct_len_t    MCT_LEN_LONG     = 3'h5;
  localparam mct_len_t    MCT_LEN_IND      = 3'h4;
  localparam mct_len_t    MCT_LEN_DISP     = 3'h5;

  // binary mode state counts
  localparam mct_states_t MCT_ST_REG_BW    = 6'h02;
  localparam mct_states_t MCT_ST_REG_D     = 6'h03;
  localparam mct_states_t MCT_ST_IMM       = 6'h03;
  localparam mct_states_t MCT_ST_IMM_EXT   = 6'h05;
  localparam mct_states_t MCT_ST_LD_B      = 6'h03;
  localparam mct_states_t MCT_ST_LD_W      = 6'h04;
  localparam mct_states_t MCT_ST_LD_D      = 6'h06;
  localparam mct_states_t MCT_ST_ST_B      = 6'h04;
  localparam mct_states_t MCT_ST_ST_W      = 6'h05;
  localparam mct_states_t MCT_ST_ST_D      = 6'h07;
  localparam mct_states_t MCT_ST_IND_LD_B  = 6'h03;
  localparam mct_states_t MCT_ST_IND_LD_W  = 6'h04;
  localparam mct_states_t MCT_ST_IND_ST_B  = 6'h04;
  localparam mct_states_t MCT_ST_IND_ST_W  = 6'h05;
  localparam mct_states_t MCT_ST_DPTR_ADD  = 6'h01;
  localparam mct_states_t MCT_ST_DISP_B    = 6'h06;
  localparam mct_states_t MCT_ST_DISP_W    = 6'h07;
  localparam mct_states_t MCT_ST_DISP_D_B  = 6'h07;

  // source mode saves one byte and one state on every form here
  localparam mct_len_t    MCT_SRC_LEN_SAVE = 3'h1;
  localparam mct_states_t MCT_SRC_ST_SAVE  = 6'h01;
  // external access costs wait states plus this
  localparam mct_states_t MCT_EXT_PENALTY  = 6'h02;
  // absolute call advances the pc by this
  localparam mct_pc_t     MCT_ABS_JSR_ADV  = 24'h000002;
  localparam int          MCT_ABS_JSR_BITS = 11;

  // values after reset, then the upper halves for immediate extension
  localparam mct_len_t    MCT_RST_LEN      = 3'h0;
  localparam mct_states_t MCT_RST_STATES   = 6'h00;
  localparam mct_pc_t     MCT_RST_PC       = 24'h000000;
  localparam logic [31:0] MCT_RST_IMM      = 32'h00000000;
  localparam logic [15:0] MCT_RST_PUSH     = 16'h0000;
  localparam logic [7:0]  MCT_RST_FLAGS    = 8'h00;
  localparam logic [15:0] MCT_ONES_HALF    = 16'hffff;
  localparam logic [15:0] MCT_ZERO_HALF    = 16'h0000;

  // one decode request
  typedef struct packed {
    mct_form_e   form;
    mct_size_e   size;
    logic        ext_mem;
    logic [3:0]  wait_n;
    logic [15:0] imm16;
  } mct_dec_req_s;

  // one decode answer
  typedef struct packed {
    logic        illegal;
    mct_len_t    len;
    mct_states_t states;
    logic [31:0] imm_value;
  } mct_dec_ans_s;

  // one flow request
  typedef struct packed {
    mct_flow_e   kind;
    mct_pc_t     pc;
    mct_len_t    instr_len;
    mct_pc_t     target;
    logic        frame_mode;
    mct_pc_t     pop_pc;
    logic [7:0]  pop_flags;
  } mct_flow_req_s;

  // one flow answer
  typedef struct packed {
    mct_pc_t     new_pc;
    logic        push_en;
    logic [15:0] push_data;
    logic        flags_load;
    logic [7:0]  flags_data;
  } mct_flow_ans_s;

endpackage

// ### rtl/mct_decoder.sv
// timing and stack-effect decoder for the data move and call/return group
// assumes requests come from logic on i_clk_sys; the mode strap is a pin
`timescale 1ns/1ns
`default_nettype none

module mct_decoder
(
  // clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst_b,
  // mode strap pin, 1 selects source mode
  input  wire logic                   i_src_mode_strap,
  // decode request
  input  wire logic                   i_dec_valid,
  input  wire mct_pkg::mct_dec_req_s  i_dec_req,
  // flow request
  input  wire logic                   i_flow_valid,
  input  wire mct_pkg::mct_flow_req_s i_flow_req,
  // mode status
  output logic                        o_mode_ready,
  output logic                        o_src_mode,
  // decode answer
  output logic                        o_dec_valid,
  output mct_pkg::mct_dec_ans_s       o_dec_ans,
  // flow answer
  output logic                        o_flow_valid,
  output mct_pkg::mct_flow_ans_s      o_flow_ans
);

  typedef struct packed {
    logic [2:0]             sync;
    logic                   locked;
    logic                   src_mode;
    logic                   dec_valid;
    mct_pkg::mct_dec_ans_s  dec;
    logic                   flow_valid;
    mct_pkg::mct_flow_ans_s flow;
  } mct_state_s;

  typedef struct packed {
    logic                 illegal;
    logic                 ext_ok;
    mct_pkg::mct_len_t    len;
    mct_pkg::mct_states_t states;
  } mct_entry_s;

  mct_state_s state_r;
  mct_state_s state_nxt;

  localparam int MCT_BITS = mct_pkg::MCT_ABS_JSR_BITS;

  // binary mode table; source mode derived by subtraction
  function automatic mct_entry_s bin_entry(input mct_pkg::mct_form_e f,
                                           input mct_pkg::mct_size_e s);
    mct_entry_s e;
    e = '{illegal: 1'b0, ext_ok: 1'b0, len: mct_pkg::MCT_RST_LEN,
          states: mct_pkg::MCT_RST_STATES};
    case (f)
      mct_pkg::MCT_F_REG:
      begin
        e.len    = mct_pkg::MCT_LEN_REG;
        e.states = (s == mct_pkg::MCT_SZ_DWORD) ? mct_pkg::MCT_ST_REG_D
                                                : mct_pkg::MCT_ST_REG_BW;
      end
      mct_pkg::MCT_F_IMM:
      begin
        case (s)
          mct_pkg::MCT_SZ_BYTE:
          begin
            e.len    = mct_pkg::MCT_LEN_IMM8;
            e.states = mct_pkg::MCT_ST_IMM;
          end
          mct_pkg::MCT_SZ_WORD:
          begin
            e.len    = mct_pkg::MCT_LEN_IMM16;
            e.states = mct_pkg::MCT_ST_IMM;
          end
          default:
          begin
            e.illegal = 1'b1;
          end
        endcase
      end
      mct_pkg::MCT_F_IMM_ZX,
      mct_pkg::MCT_F_IMM_OX:
      begin
        e.illegal = (s != mct_pkg::MCT_SZ_DWORD);
        e.len     = mct_pkg::MCT_LEN_IMM16;
        e.states  = mct_pkg::MCT_ST_IMM_EXT;
      end
      mct_pkg::MCT_F_LD_SHORT,
      mct_pkg::MCT_F_LD_LONG:
      begin
        // short direct space is on-chip, so no wait penalty there
        e.ext_ok = (f == mct_pkg::MCT_F_LD_LONG);
        e.len    = e.ext_ok ? mct_pkg::MCT_LEN_LONG : mct_pkg::MCT_LEN_SHORT;
        case (s)
          mct_pkg::MCT_SZ_BYTE:  e.states = mct_pkg::MCT_ST_LD_B;
          mct_pkg::MCT_SZ_WORD:  e.states = mct_pkg::MCT_ST_LD_W;
          default:               e.states = mct_pkg::MCT_ST_LD_D;
        endcase
      end
      mct_pkg::MCT_F_ST_SHORT,
      mct_pkg::MCT_F_ST_LONG:
      begin
        e.ext_ok = (f == mct_pkg::MCT_F_ST_LONG);
        e.len    = e.ext_ok ? mct_pkg::MCT_LEN_LONG : mct_pkg::MCT_LEN_SHORT;
        case (s)
          mct_pkg::MCT_SZ_BYTE:  e.states = mct_pkg::MCT_ST_ST_B;
          mct_pkg::MCT_SZ_WORD:  e.states = mct_pkg::MCT_ST_ST_W;
          default:               e.states = mct_pkg::MCT_ST_ST_D;
        endcase
      end
      mct_pkg::MCT_F_LD_IND_W,
      mct_pkg::MCT_F_LD_IND_D:
      begin
        // dword destinations have no indirect form
        e.illegal = (s == mct_pkg::MCT_SZ_DWORD);
        e.ext_ok  = 1'b1;
        e.len     = mct_pkg::MCT_LEN_IND;
        e.states  = (s == mct_pkg::MCT_SZ_BYTE) ? mct_pkg::MCT_ST_IND_LD_B
                                                : mct_pkg::MCT_ST_IND_LD_W;
        if (f == mct_pkg::MCT_F_LD_IND_D)
        begin
          e.states = e.states + mct_pkg::MCT_ST_DPTR_ADD;
        end
      end
      mct_pkg::MCT_F_ST_IND_W,
      mct_pkg::MCT_F_ST_IND_D:
      begin
        e.illegal = (s == mct_pkg::MCT_SZ_DWORD);
        e.ext_ok  = 1'b1;
        e.len     = mct_pkg::MCT_LEN_IND;
        e.states  = (s == mct_pkg::MCT_SZ_BYTE) ? mct_pkg::MCT_ST_IND_ST_B
                                                : mct_pkg::MCT_ST_IND_ST_W;
        if (f == mct_pkg::MCT_F_ST_IND_D)
        begin
          e.states = e.states + mct_pkg::MCT_ST_DPTR_ADD;
        end
      end
      mct_pkg::MCT_F_LD_DISP_W:
      begin
        e.illegal = (s == mct_pkg::MCT_SZ_DWORD);
        e.ext_ok  = 1'b1;
        e.len     = mct_pkg::MCT_LEN_DISP;
        e.states  = (s == mct_pkg::MCT_SZ_BYTE) ? mct_pkg::MCT_ST_DISP_B
                                                : mct_pkg::MCT_ST_DISP_W;
      end
      mct_pkg::MCT_F_LD_DISP_D:
      begin
        // only the byte destination exists through a dword pointer
        e.illegal = (s != mct_pkg::MCT_SZ_BYTE);
        e.ext_ok  = 1'b1;
        e.len     = mct_pkg::MCT_LEN_DISP;
        e.states  = mct_pkg::MCT_ST_DISP_D_B;
      end
      default:
      begin
        e.illegal = 1'b1;
      end
    endcase
    return e;
  endfunction

  // immediate value as it lands in the destination register
  function automatic logic [31:0] imm_extend(input mct_pkg::mct_form_e f,
                                             input logic [15:0] v);
    logic [31:0] r;
    r = {mct_pkg::MCT_ZERO_HALF, v};
    case (f)
      mct_pkg::MCT_F_IMM_OX: r = {mct_pkg::MCT_ONES_HALF, v};
      default:               r = {mct_pkg::MCT_ZERO_HALF, v};
    endcase
    return r;
  endfunction

  always_comb
  begin
    mct_entry_s e;
    mct_pkg::mct_pc_t pc_next;
    e         = bin_entry(i_dec_req.form, i_dec_req.size);
    pc_next   = mct_pkg::MCT_RST_PC;
    state_nxt = state_r;

    // strap passes three flops; taken once the last two agree
    state_nxt.sync = {state_r.sync[1:0], i_src_mode_strap};
    if (!state_r.locked && (state_r.sync[1] == state_r.sync[2]))
    begin
      state_nxt.locked   = 1'b1;
      state_nxt.src_mode = state_r.sync[2];
    end

    // decode path; requests before the mode is known are dropped
    state_nxt.dec_valid = i_dec_valid && state_r.locked;
    if (i_dec_valid && state_r.locked)
    begin
      if (state_r.src_mode)
      begin
        e.len    = e.len - mct_pkg::MCT_SRC_LEN_SAVE;
        e.states = e.states - mct_pkg::MCT_SRC_ST_SAVE;
      end
      if (e.ext_ok && i_dec_req.ext_mem)
      begin
        e.states = e.states + {2'h0, i_dec_req.wait_n} + mct_pkg::MCT_EXT_PENALTY;
      end
      state_nxt.dec.illegal   = e.illegal;
      state_nxt.dec.len       = e.len;
      state_nxt.dec.states    = e.states;
      state_nxt.dec.imm_value = imm_extend(i_dec_req.form, i_dec_req.imm16);
    end

    // flow path
    state_nxt.flow_valid = i_flow_valid;
    if (i_flow_valid)
    begin
      state_nxt.flow.flags_load = 1'b0;
      state_nxt.flow.flags_data = mct_pkg::MCT_RST_FLAGS;
      case (i_flow_req.kind)
        mct_pkg::MCT_K_ABSOLUTE_PAGE_JSR:
        begin
          pc_next                  = i_flow_req.pc + mct_pkg::MCT_ABS_JSR_ADV;
          state_nxt.flow.push_en   = 1'b1;
          state_nxt.flow.push_data = pc_next[15:0];
          state_nxt.flow.new_pc    = {pc_next[23:MCT_BITS],
                                      i_flow_req.target[MCT_BITS-1:0]};
        end
        mct_pkg::MCT_K_LONG_JSR_OP:
        begin
          pc_next                  = i_flow_req.pc + {21'h0, i_flow_req.instr_len};
          state_nxt.flow.push_en   = 1'b1;
          state_nxt.flow.push_data = pc_next[15:0];
          // long call stays inside the 64K region of the return address
          state_nxt.flow.new_pc    = {pc_next[23:16], i_flow_req.target[15:0]};
        end
        mct_pkg::MCT_K_SUBROUTINE_EXIT:
        begin
          state_nxt.flow.push_en   = 1'b0;
          state_nxt.flow.push_data = mct_pkg::MCT_RST_PUSH;
          state_nxt.flow.new_pc    = {i_flow_req.pc[23:16], i_flow_req.pop_pc[15:0]};
        end
        mct_pkg::MCT_K_INTERRUPT_EXIT:
        begin
          state_nxt.flow.push_en   = 1'b0;
          state_nxt.flow.push_data = mct_pkg::MCT_RST_PUSH;
          if (i_flow_req.frame_mode)
          begin
            state_nxt.flow.new_pc     = i_flow_req.pop_pc;
            state_nxt.flow.flags_load = 1'b1;
            state_nxt.flow.flags_data = i_flow_req.pop_flags;
          end
          else
          begin
            state_nxt.flow.new_pc = {i_flow_req.pc[23:16], i_flow_req.pop_pc[15:0]};
          end
        end
        default:
        begin
          state_nxt.flow.push_en = 1'b0;
        end
      endcase
    end

    if (!i_rst_b)
    begin
      // last two stages start unequal, so no lock before the strap has reached the middle stage
      state_nxt.sync       = 3'h2;
      state_nxt.locked     = 1'b0;
      state_nxt.src_mode   = 1'b0;
      state_nxt.dec_valid  = 1'b0;
      state_nxt.dec        = '{illegal: 1'b0, len: mct_pkg::MCT_RST_LEN,
                               states: mct_pkg::MCT_RST_STATES,
                               imm_value: mct_pkg::MCT_RST_IMM};
      state_nxt.flow_valid = 1'b0;
      state_nxt.flow       = '{new_pc: mct_pkg::MCT_RST_PC, push_en: 1'b0,
                               push_data: mct_pkg::MCT_RST_PUSH, flags_load: 1'b0,
                               flags_data: mct_pkg::MCT_RST_FLAGS};
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    state_r <= state_nxt;
  end

  assign o_mode_ready = state_r.locked;
  assign o_src_mode   = state_r.src_mode;
  assign o_dec_valid  = state_r.dec_valid;
  assign o_dec_ans    = state_r.dec;
  assign o_flow_valid = state_r.flow_valid;
  assign o_flow_ans   = state_r.flow;

endmodule

`default_nettype wire

// ### tb/mct_decoder_checker.sv
// port-level assertions for the move/call timing decoder
// assumes one clock domain; bound to every mct_decoder instance
`timescale 1ns/1ns
`default_nettype none

module mct_decoder_checker
(
  // clock and reset
  input wire logic                   i_clk_sys,
  input wire logic                   i_rst_b,
  // requests
  input wire logic                   i_src_mode_strap,
  input wire logic                   i_dec_valid,
  input wire mct_pkg::mct_dec_req_s  i_dec_req,
  input wire logic                   i_flow_valid,
  input wire mct_pkg::mct_flow_req_s i_flow_req,
  // answers
  input wire logic                   o_mode_ready,
  input wire logic                   o_src_mode,
  input wire logic                   o_dec_valid,
  input wire mct_pkg::mct_dec_ans_s  o_dec_ans,
  input wire logic                   o_flow_valid,
  input wire mct_pkg::mct_flow_ans_s o_flow_ans
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  logic take;
  assign take = i_dec_valid && o_mode_ready;

  AST_DEC_ANSWER: assert property (take |=> o_dec_valid)
    else $error("decode answer missing");
  AST_DEC_DROP: assert property (i_dec_valid && !o_mode_ready |=> !o_dec_valid)
    else $error("decode answered before mode known");
  AST_MODE_HOLD: assert property (o_mode_ready |=> o_mode_ready && $stable(o_src_mode))
    else $error("opcode mode changed in operation");
  AST_REG_WIDE: assert property (take && i_dec_req.form == mct_pkg::MCT_F_REG
    && i_dec_req.size == mct_pkg::MCT_SZ_DWORD && !o_src_mode
    |=> o_dec_ans.len == 3'h3 && o_dec_ans.states == 6'h03)
    else $error("dword register move timing wrong");
  AST_REG_SRC: assert property (take && i_dec_req.form == mct_pkg::MCT_F_REG
    && i_dec_req.size != mct_pkg::MCT_SZ_DWORD && o_src_mode
    |=> o_dec_ans.len == 3'h2 && o_dec_ans.states == 6'h01)
    else $error("source mode register move timing wrong");
  AST_ZERO_EXT: assert property (take && i_dec_req.form == mct_pkg::MCT_F_IMM_ZX
    && i_dec_req.size == mct_pkg::MCT_SZ_DWORD
    |=> !o_dec_ans.illegal && o_dec_ans.imm_value[31:16] == 16'h0000)
    else $error("zero extension upper half not clear");
  AST_ONE_EXT: assert property (take && i_dec_req.form == mct_pkg::MCT_F_IMM_OX
    && i_dec_req.size == mct_pkg::MCT_SZ_DWORD
    |=> o_dec_ans.imm_value == {16'hffff, $past(i_dec_req.imm16)})
    else $error("one extension value wrong");
  AST_EXT_WAIT: assert property (take && i_dec_req.form == mct_pkg::MCT_F_LD_LONG
    && i_dec_req.size == mct_pkg::MCT_SZ_BYTE && i_dec_req.ext_mem && !o_src_mode
    |=> o_dec_ans.states == 6'h05 + 6'($past(i_dec_req.wait_n)))
    else $error("external wait penalty wrong");
  AST_ABS_PUSH: assert property (i_flow_valid
    && i_flow_req.kind == mct_pkg::MCT_K_ABSOLUTE_PAGE_JSR
    |=> o_flow_valid && o_flow_ans.push_en
    && o_flow_ans.push_data == 16'($past(i_flow_req.pc) + 24'h000002))
    else $error("absolute call push wrong");
  AST_LONG_PUSH: assert property (i_flow_valid
    && i_flow_req.kind == mct_pkg::MCT_K_LONG_JSR_OP
    |=> o_flow_ans.push_en && o_flow_ans.push_data
    == 16'($past(i_flow_req.pc) + 24'($past(i_flow_req.instr_len))))
    else $error("long call push wrong");
  AST_SUB_EXIT: assert property (i_flow_valid
    && i_flow_req.kind == mct_pkg::MCT_K_SUBROUTINE_EXIT
    |=> !o_flow_ans.push_en && !o_flow_ans.flags_load
    && o_flow_ans.new_pc[15:0] == 16'($past(i_flow_req.pop_pc)))
    else $error("plain return pop wrong");
  AST_FRAME_POP: assert property (i_flow_valid && i_flow_req.frame_mode
    && i_flow_req.kind == mct_pkg::MCT_K_INTERRUPT_EXIT
    |=> o_flow_ans.flags_load && o_flow_ans.new_pc == $past(i_flow_req.pop_pc)
    && o_flow_ans.flags_data == $past(i_flow_req.pop_flags))
    else $error("wide interrupt return pop wrong");
endmodule

bind mct_decoder mct_decoder_checker chk_i (.i_clk_sys, .i_rst_b, .i_src_mode_strap,
  .i_dec_valid, .i_dec_req, .i_flow_valid, .i_flow_req, .o_mode_ready, .o_src_mode,
  .o_dec_valid, .o_dec_ans, .o_flow_valid, .o_flow_ans);

`default_nettype wire

// ### tb/mct_stack_model.sv
// stack memory behind the decoder's push and pop answers
// assumes the bench asks for a pop in the cycle it sends a return
`timescale 1ns/1ns
`default_nettype none

module mct_stack_model
(
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  // push side
  input  wire logic        i_push,
  input  wire logic [15:0] i_push_data,
  // pop side
  input  wire logic        i_pop,
  output logic      [23:0] o_top,
  output logic      [7:0]  o_flags
);
  logic [15:0] mem [16];
  logic [3:0]  sp;
  logic [7:0]  churn;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
      churn <= 8'ha5;
    else
      churn <= churn + 8'h5b;
    if (!i_rst_b)
      sp <= 4'h0;
    else if (i_push)
    begin
      mem[sp] <= i_push_data;
      sp      <= sp + 4'h1;
    end
    else if (i_pop && sp != 4'h0)
      sp <= sp - 4'h1;
  end

  // only 16 bits go on per push, so the upper byte of a wide pop is noise
  assign o_top   = (sp == 4'h0) ? {churn, ~churn, churn} : {churn, mem[sp - 4'h1]};
  assign o_flags = ~churn;
endmodule

`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the move/call timing decoder
// assumes nothing outside: drives every input and models the stack
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic                   i_clk_sys;
  logic                   i_rst_b;
  logic                   strap;
  logic                   dec_v;
  logic                   flow_v;
  logic                   pop;
  logic                   ready;
  logic                   src;
  logic                   dv;
  logic                   fv;
  mct_pkg::mct_dec_req_s  dreq;
  mct_pkg::mct_flow_req_s freq;
  mct_pkg::mct_dec_ans_s  dans;
  mct_pkg::mct_flow_ans_s fans;
  logic [23:0]            top;
  logic [7:0]             tflags;
  int                     n_fail;
  int                     n_compared;
  int                     i;
  logic                   hung;
  // binary states per form and size, 0 marks an illegal pair
  int st_tab [14][3] = '{'{2,2,3}, '{3,3,0}, '{0,0,5}, '{0,0,5}, '{3,4,6}, '{3,4,6},
    '{4,5,7}, '{4,5,7}, '{3,4,0}, '{4,5,0}, '{4,5,0}, '{5,6,0}, '{6,7,0}, '{7,0,0}};
  int ln_tab [14] = '{3,4,5,5,4,5,4,5,4,4,4,4,5,5};

  initial i_clk_sys = 1'b0;
  always #50 i_clk_sys = ~i_clk_sys;

  mct_decoder uut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_src_mode_strap(strap),
    .i_dec_valid(dec_v), .i_dec_req(dreq), .i_flow_valid(flow_v), .i_flow_req(freq),
    .o_mode_ready(ready), .o_src_mode(src), .o_dec_valid(dv), .o_dec_ans(dans),
    .o_flow_valid(fv), .o_flow_ans(fans));

  mct_stack_model stk (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_push(fv && fans.push_en), .i_push_data(fans.push_data), .i_pop(pop),
    .o_top(top), .o_flags(tflags));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic mct_pkg::mct_dec_ans_s exp_dec(input mct_pkg::mct_dec_req_s r,
                                                    input logic s);
    mct_pkg::mct_dec_ans_s a;
    int f;
    int z;
    f = int'(r.form);
    z = int'(r.size);
    a = '0;
    a.illegal = (st_tab[f][z] == 0);
    a.states = 6'(st_tab[f][z]);
    a.len = 3'(ln_tab[f] + ((f == 1 && z == 1) ? 1 : 0));
    if (s)
    begin
      a.len = a.len - 3'h1;
      a.states = a.states - 6'h01;
    end
    // short direct space is on-chip, so it never pays the wait penalty
    if (r.ext_mem && (f == 5 || f >= 7))
      a.states = a.states + 6'(r.wait_n) + 6'h02;
    a.imm_value = {(f == 3) ? 16'hffff : 16'h0000, r.imm16};
    return a;
  endfunction

  task automatic dec(input int f, input int z, input logic x, input logic [3:0] w);
    mct_pkg::mct_dec_req_s r;
    mct_pkg::mct_dec_ans_s e;
    r = '{form: mct_pkg::mct_form_e'(f), size: mct_pkg::mct_size_e'(z), ext_mem: x,
          wait_n: w, imm16: 16'($urandom)};
    e = exp_dec(r, src);
    dec_v = 1'b1;
    dreq = r;
    @(negedge i_clk_sys);
    chk(dv, 1'b1);
    chk(dans.illegal, e.illegal);
    if (!e.illegal)
    begin
      chk(dans.len, e.len);
      chk(dans.states, e.states);
      chk(dans.imm_value, e.imm_value);
    end
  endtask

  task automatic flow(input int k, input logic [23:0] pc);
    mct_pkg::mct_flow_req_s r;
    logic [23:0]            nx;
    logic [23:0]            epc;
    r = '{kind: mct_pkg::mct_flow_e'(k), pc: pc, instr_len: 3'($urandom_range(5, 1)),
          target: 24'($urandom), frame_mode: 1'($urandom), pop_pc: top, pop_flags: tflags};
    nx = (k == 0) ? pc + 24'h000002 : pc + 24'(r.instr_len);
    epc = (k == 0) ? {nx[23:11], r.target[10:0]} :
          (k == 1) ? {nx[23:16], r.target[15:0]} :
          (k == 3 && r.frame_mode) ? r.pop_pc : {pc[23:16], r.pop_pc[15:0]};
    pop = (k >= 2);
    flow_v = 1'b1;
    freq = r;
    @(negedge i_clk_sys);
    chk(fv, 1'b1);
    chk(fans.push_en, k < 2);
    if (k < 2)
      chk(fans.push_data, nx[15:0]);
    chk(fans.new_pc, epc);
    chk(fans.flags_load, k == 3 && r.frame_mode);
    if (k == 3 && r.frame_mode)
      chk(fans.flags_data, r.pop_flags);
  endtask

  task automatic do_reset(input logic s);
    int k;
    i_rst_b = 1'b0;
    strap = s;
    repeat (20) @(negedge i_clk_sys);
    chk({ready, dv, fv}, 3'b000);
    i_rst_b = 1'b1;
    dec_v = 1'b1;
    @(negedge i_clk_sys);
    dec_v = 1'b0;
    chk(dv, 1'b0);
    k = 0;
    while (ready !== 1'b1 && k < 10)
    begin
      @(negedge i_clk_sys);
      k++;
    end
    if (ready !== 1'b1)
    begin
      // mode never latched: counted, and the caller stops the run
      n_fail++;
      hung = 1'b1;
    end
    else
    begin
      chk(src, s);
      strap = ~s;
      repeat (5) @(negedge i_clk_sys);
      chk(src, s);
    end
  endtask

  initial
  begin
    i_rst_b = 1'b0;
    strap = 1'b0;
    dec_v = 1'b0;
    flow_v = 1'b0;
    pop = 1'b0;
    dreq = '0;
    freq = '0;
    n_fail = 0;
    n_compared = 0;
    hung = 1'b0;
    void'($urandom(51));
    @(negedge i_clk_sys);
    for (int m = 0; m < 2; m++)
    begin
      do_reset(1'(m));
      if (hung)
        break;
      // every form and size back to back, longest wait
      for (i = 0; i < 42; i++)
        dec(i / 3, i % 3, 1'b1, 4'hf);
      for (i = 0; i < 300; i++)
        dec($urandom_range(13), $urandom_range(2), 1'($urandom), 4'($urandom));
      dec_v = 1'b0;
      // carries out of the low 16 bits
      flow(0, 24'h00fffe);
      flow(1, 24'hfffffe);
      for (i = 0; i < 200; i++)
        flow($urandom_range(3), 24'($urandom));
      flow_v = 1'b0;
      pop = 1'b0;
    end
    final_report();
  end
endmodule

`default_nettype wire
